// >>> verilog/mbsc_core.sv
// execution unit for skip, flow and system control operations
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - equal compare skips next instruction when accumulator equals operand
// - not-equal compare skips next instruction when accumulator differs
// - compares set Z, C, AC, OV like accumulator minus operand
// - io bit test skips on low or high, flags kept
// - memory bit test skips on low or high, flags kept
// - increment writes back, sets four flags, skips on zero
// - decrement writes back, sets four flags, skips on zero
// - call stores pc plus one at sp, sp plus 2, loads target
// - jump loads any program address, flags kept
// - return with value loads accumulator then returns
// - return lowers sp by 2 and reloads pc from stack
// - interrupt return sets global enable after completing
// - computed jump sets pc to pc plus accumulator
// - interrupt-on sets global enable
// - interrupt-off clears global enable
// - system halt stops all clocks and oscillators
// - cpu halt gates cpu clock, oscillators keep running
// - software reset acts exactly like hardware reset
// - watchdog clear restarts watchdog count, flags kept
// - flow changes and indirect move take two cycles, others one
// - skip instructions take two cycles on skip, one otherwise
// - bit access to data ram limited to addresses 0x00 to 0x3f
module mbsc_core #(
  parameter int PC_W = 11,
  parameter int SP_W = 8
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_instr_valid,
  input  wire mbsc_pkg::mbsc_op_t   i_op,
  input  wire logic                 i_use_mem,
  input  wire logic [7:0]           i_imm,
  input  wire logic [7:0]           i_mem_rdata,
  input  wire logic [7:0]           i_io_rdata,
  input  wire logic [7:0]           i_mem_addr,
  input  wire logic [2:0]           i_bit_sel,
  input  wire logic                 i_bit_io,
  input  wire logic [PC_W-1:0]      i_target,
  input  wire logic [PC_W-1:0]      i_stack_rdata,
  input  wire logic                 i_wake,
  output logic [PC_W-1:0]           o_pc,
  output logic [7:0]                o_acc,
  output logic [3:0]                o_flags,
  output logic [SP_W-1:0]           o_sp,
  output logic                      o_gie,
  output logic                      o_mem_we,
  output logic [7:0]                o_mem_wdata,
  output logic                      o_stack_we,
  output logic [PC_W-1:0]           o_stack_wdata,
  output logic                      o_busy,
  output logic                      o_suppress,
  output logic                      o_bit_addr_err,
  output logic                      o_sys_halt,
  output logic                      o_cpu_halt,
  output logic                      o_chip_reset,
  output logic                      o_wdt_clear
);
  import mbsc_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (PC_W < 8 || PC_W > 16) begin : g_pc_chk
    $error("PC_W must lie between 8 and 16");
  end
  if (SP_W != 8) begin : g_sp_chk
    $error("SP_W must be 8");
  end

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    mbsc_state_t     st;
    logic [PC_W-1:0] pc;
    logic [7:0]      acc;
    logic [3:0]      flags;
    logic [SP_W-1:0] sp;
    logic            gie;
    logic            gie_pend;
    logic            mem_we;
    logic [7:0]      mem_wdata;
    logic            stack_we;
    logic [PC_W-1:0] stack_wdata;
    logic            suppress;
    logic            bit_err;
    logic            sys_halt;
    logic            cpu_halt;
    logic            chip_reset;
    logic            wdt_clear;
    logic            busy;        // second slot of a two-cycle operation
    logic            ret_pend;    // next slot loads pc from the stack port
    logic            wake_m;      // wake synchroniser, first stage
    logic            wake_s;      // wake synchroniser, second stage
  } mbsc_reg_t;

  mbsc_reg_t s_q;
  mbsc_reg_t s_d;

  // ****************************************
  // arithmetic helpers
  // ****************************************
  // flags of a - b, as a subtract would leave them
  function automatic logic [3:0] mbsc_sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] res;
    logic [3:0] f;
    full = {1'b0, a} - {1'b0, b};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    res  = full[7:0];
    f = 4'h0;
    f[MBSC_FLAG_Z]  = (res == 8'h00);
    f[MBSC_FLAG_C]  = full[8];
    f[MBSC_FLAG_AC] = low[4];
    f[MBSC_FLAG_OV] = (a[7] ^ b[7]) & (a[7] ^ res[7]);
    return f;
  endfunction : mbsc_sub_flags

  // flags of a + b
  function automatic logic [3:0] mbsc_add_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] res;
    logic [3:0] f;
    full = {1'b0, a} + {1'b0, b};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    res  = full[7:0];
    f = 4'h0;
    f[MBSC_FLAG_Z]  = (res == 8'h00);
    f[MBSC_FLAG_C]  = full[8];
    f[MBSC_FLAG_AC] = low[4];
    f[MBSC_FLAG_OV] = ~(a[7] ^ b[7]) & (a[7] ^ res[7]);
    return f;
  endfunction : mbsc_add_flags

  // ****************************************
  // operand selection
  // ****************************************
  logic [7:0] opnd;
  logic [7:0] src;
  logic [7:0] tbyte;
  logic       tbit;
  logic [7:0] inc_res;
  logic [7:0] dec_res;
  logic       bit_ok;
  logic [7:0] step_res;
  logic [3:0] step_flags;

  // compare operand is immediate or memory; inc/dec target is acc or memory
  always_comb begin
    opnd    = i_use_mem ? i_mem_rdata : i_imm;
    src     = i_use_mem ? i_mem_rdata : s_q.acc;
    tbyte   = i_bit_io ? i_io_rdata : i_mem_rdata;
    tbit    = tbyte[i_bit_sel];
    inc_res = src + 8'h01;
    dec_res = src - 8'h01;
    bit_ok  = i_bit_io || (i_mem_addr <= MBSC_BIT_RAM_HI);
    // one adder pair serves both step operations
    step_res   = (i_op == MBSC_OP_INCSZ) ? inc_res : dec_res;
    step_flags = (i_op == MBSC_OP_INCSZ) ? mbsc_add_flags(src, 8'h01)
                                         : mbsc_sub_flags(src, 8'h01);
  end

  // ****************************************
  // next state
  // ****************************************
  // one instruction per EXEC cycle; EXTRA covers the second cycle of
  // two-cycle operations and the suppressed slot after a skip
  always_comb begin
    s_d            = s_q;
    s_d.mem_we     = 1'b0;
    s_d.stack_we   = 1'b0;
    s_d.wdt_clear  = 1'b0;
    s_d.chip_reset = 1'b0;
    s_d.bit_err    = 1'b0;
    // wake comes from a pin: two stages before the sequencer looks at it
    s_d.wake_m     = i_wake;
    s_d.wake_s     = s_q.wake_m;
    case (s_q.st)
      MBSC_ST_EXEC: begin
        s_d.suppress = 1'b0;
        if (i_instr_valid) begin
          s_d.pc = s_q.pc + PC_W'(1);
          case (i_op)
            MBSC_OP_CEQ, MBSC_OP_CNEQ: begin
              s_d.flags = mbsc_sub_flags(s_q.acc, opnd);
              if ((s_q.acc == opnd) == (i_op == MBSC_OP_CEQ)) begin
                s_d.st       = MBSC_ST_EXTRA;
                s_d.suppress = 1'b1;
              end
            end
            MBSC_OP_TBIT_LO, MBSC_OP_TBIT_HI: begin
              // out-of-range ram bit address is flagged and never skips
              s_d.bit_err = ~bit_ok;
              if (bit_ok && (tbit == (i_op == MBSC_OP_TBIT_HI))) begin
                s_d.st       = MBSC_ST_EXTRA;
                s_d.suppress = 1'b1;
              end
            end
            MBSC_OP_INCSZ, MBSC_OP_DECSZ: begin
              s_d.flags = step_flags;
              if (i_use_mem) begin
                s_d.mem_we    = 1'b1;
                s_d.mem_wdata = step_res;
              end else begin
                s_d.acc = step_res;
              end
              if (step_res == 8'h00) begin
                s_d.st       = MBSC_ST_EXTRA;
                s_d.suppress = 1'b1;
              end
            end
            MBSC_OP_CALL: begin
              s_d.stack_we    = 1'b1;
              s_d.stack_wdata = s_q.pc + PC_W'(1);
              s_d.sp          = s_q.sp + MBSC_SP_STEP;
              s_d.pc          = i_target;
              s_d.st          = MBSC_ST_EXTRA;
            end
            MBSC_OP_JUMP: begin
              s_d.pc = i_target;
              s_d.st = MBSC_ST_EXTRA;
            end
            MBSC_OP_RETV, MBSC_OP_RET, MBSC_OP_RETI: begin
              if (i_op == MBSC_OP_RETV) begin
                s_d.acc = i_imm;
              end
              // the stack port shows the slot at the lowered pointer next cycle
              s_d.sp       = s_q.sp - MBSC_SP_STEP;
              s_d.gie_pend = (i_op == MBSC_OP_RETI);
              s_d.ret_pend = 1'b1;
              s_d.st       = MBSC_ST_EXTRA;
            end
            MBSC_OP_PCADD: begin
              s_d.pc = s_q.pc + PC_W'(s_q.acc);
              s_d.st = MBSC_ST_EXTRA;
            end
            MBSC_OP_IDXM: begin
              s_d.st = MBSC_ST_EXTRA;
            end
            MBSC_OP_GIE_ON:  s_d.gie = 1'b1;
            MBSC_OP_GIE_OFF: s_d.gie = 1'b0;
            MBSC_OP_SYSHALT: begin
              s_d.sys_halt = 1'b1;
              s_d.st       = MBSC_ST_HALT;
            end
            MBSC_OP_CPUHALT: begin
              s_d.cpu_halt = 1'b1;
              s_d.st       = MBSC_ST_HALT;
            end
            MBSC_OP_SWRESET: s_d.chip_reset = 1'b1;
            MBSC_OP_WDCLR:   s_d.wdt_clear  = 1'b1;
            default: ; // one-cycle operations handled elsewhere
          endcase
        end
      end
      MBSC_ST_EXTRA: begin
        // skipped slot: the fetched word is consumed with no effect
        if (s_q.suppress) begin
          s_d.pc = s_q.pc + PC_W'(1);
        end
        // the return address stands on the stack port in this slot
        if (s_q.ret_pend) begin
          s_d.pc = i_stack_rdata;
        end
        // enable rises only as the return completes, so a pending
        // request cannot re-enter before the old frame is unwound
        s_d.gie      = s_q.gie | s_q.gie_pend;
        s_d.gie_pend = 1'b0;
        s_d.ret_pend = 1'b0;
        s_d.suppress = 1'b0;
        s_d.st       = MBSC_ST_EXEC;
      end
      MBSC_ST_HALT: begin
        // only the synchronised wake restarts; oscillators live outside
        if (s_q.wake_s) begin
          s_d.sys_halt = 1'b0;
          s_d.cpu_halt = 1'b0;
          s_d.st       = MBSC_ST_EXEC;
        end
      end
      default: s_d.st = MBSC_ST_EXEC;
    endcase
    // busy marks the second slot only; a halt shows on its own flags
    s_d.busy = (s_d.st == MBSC_ST_EXTRA);
  end

  // ****************************************
  // reset image
  // ****************************************
  // whole record at reset; the wake stages start low so no false
  // wake follows reset
  function automatic mbsc_reg_t mbsc_rst_val();
    mbsc_reg_t v;
    v     = '0;
    v.st  = MBSC_ST_EXEC;
    v.pc  = PC_W'(MBSC_PC_RST);
    v.acc = MBSC_ACC_RST;
    v.sp  = SP_W'(MBSC_SP_RST);
    return v;
  endfunction : mbsc_rst_val

  // ****************************************
  // state register
  // ****************************************
  // synchronous reset; a software reset returns through i_rst, which
  // gives it exactly the hardware reset's effect
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= mbsc_rst_val();
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a field of the record, so each leaves a flop
  assign o_pc           = s_q.pc;
  assign o_acc          = s_q.acc;
  assign o_flags        = s_q.flags;
  assign o_sp           = s_q.sp;
  assign o_gie          = s_q.gie;
  assign o_mem_we       = s_q.mem_we;
  assign o_mem_wdata    = s_q.mem_wdata;
  assign o_stack_we     = s_q.stack_we;
  assign o_stack_wdata  = s_q.stack_wdata;
  assign o_busy         = s_q.busy;
  assign o_suppress     = s_q.suppress;
  assign o_bit_addr_err = s_q.bit_err;
  assign o_sys_halt     = s_q.sys_halt;
  assign o_cpu_halt     = s_q.cpu_halt;
  assign o_chip_reset   = s_q.chip_reset;
  assign o_wdt_clear    = s_q.wdt_clear;
endmodule : mbsc_core
`default_nettype wire

// >>> verilog/mbsc_pkg.sv
// constants and types shared by the branch and system control unit
`default_nettype none
package mbsc_pkg;
  // ****************************************
  // operation codes presented by the decoder
  // ****************************************
  typedef enum logic [4:0] {
    MBSC_OP_NONE     = 5'h00,
    MBSC_OP_CEQ      = 5'h01,
    MBSC_OP_CNEQ     = 5'h02,
    MBSC_OP_TBIT_LO  = 5'h03,
    MBSC_OP_TBIT_HI  = 5'h04,
    MBSC_OP_INCSZ    = 5'h05,
    MBSC_OP_DECSZ    = 5'h06,
    MBSC_OP_CALL     = 5'h07,
    MBSC_OP_JUMP     = 5'h08,
    MBSC_OP_RETV     = 5'h09,
    MBSC_OP_RET      = 5'h0a,
    MBSC_OP_RETI     = 5'h0b,
    MBSC_OP_PCADD    = 5'h0c,
    MBSC_OP_GIE_ON   = 5'h0d,
    MBSC_OP_GIE_OFF  = 5'h0e,
    MBSC_OP_SYSHALT  = 5'h0f,
    MBSC_OP_CPUHALT  = 5'h10,
    MBSC_OP_SWRESET  = 5'h11,
    MBSC_OP_WDCLR    = 5'h12,
    MBSC_OP_IDXM     = 5'h13,
    MBSC_OP_OTHER    = 5'h14
  } mbsc_op_t;

  // ****************************************
  // execution sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    MBSC_ST_EXEC  = 2'b00,
    MBSC_ST_EXTRA = 2'b01,
    MBSC_ST_HALT  = 2'b10
  } mbsc_state_t;

  // ****************************************
  // widths, reset values and limits
  // ****************************************
  localparam int          MBSC_PC_W       = 11;
  localparam int          MBSC_SP_W       = 8;
  localparam logic [7:0]  MBSC_SP_STEP    = 8'h02;
  localparam logic [7:0]  MBSC_BIT_RAM_HI = 8'h3f;
  localparam logic [10:0] MBSC_PC_RST     = 11'h000;
  localparam logic [7:0]  MBSC_SP_RST     = 8'h00;
  localparam logic [7:0]  MBSC_ACC_RST    = 8'h00;
  localparam int          MBSC_FLAG_Z     = 0;
  localparam int          MBSC_FLAG_C     = 1;
  localparam int          MBSC_FLAG_AC    = 2;
  localparam int          MBSC_FLAG_OV    = 3;
endpackage : mbsc_pkg
`default_nettype wire

// >>> tb/mbsc_core_asserts.sv
// concurrent checks on the skip, flow and system control core
`timescale 1ns/100ps
`default_nettype none
module mbsc_core_asserts import mbsc_pkg::*; #(
  parameter int PC_W = 11,
  parameter int SP_W = 8
) (
  input wire logic               i_sys_clk,
  input wire logic               i_rst,
  input wire logic               i_instr_valid,
  input wire mbsc_pkg::mbsc_op_t i_op,
  input wire logic               i_use_mem,
  input wire logic [7:0]         i_imm,
  input wire logic [7:0]         i_mem_rdata,
  input wire logic [PC_W-1:0]    i_target,
  input wire logic [PC_W-1:0]    o_pc,
  input wire logic [7:0]         o_acc,
  input wire logic [3:0]         o_flags,
  input wire logic [SP_W-1:0]    o_sp,
  input wire logic               o_gie,
  input wire logic               o_busy,
  input wire logic               o_suppress,
  input wire logic               o_sys_halt,
  input wire logic               o_cpu_halt
);
  logic       take;
  logic [7:0] opnd;
  // only an idle, running core takes an instruction
  assign take = i_instr_valid && !o_busy && !o_sys_halt && !o_cpu_halt;
  assign opnd = i_use_mem ? i_mem_rdata : i_imm;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ****************************************
  // skip, flow and enable checks
  // ****************************************
  AST_SKIP: assert property (
    take && (i_op == MBSC_OP_CEQ && o_acc == opnd || i_op == MBSC_OP_CNEQ && o_acc != opnd)
    |=> o_busy && o_suppress) else $error("compare skip missing");
  AST_TBIT_FLAGS: assert property (
    take && i_op inside {[MBSC_OP_TBIT_LO:MBSC_OP_TBIT_HI]} |=> o_flags == $past(o_flags))
    else $error("bit test changed flags");
  AST_CALL_SP: assert property (
    take && i_op == MBSC_OP_CALL |=> o_sp == SP_W'($past(o_sp) + MBSC_SP_STEP))
    else $error("call stack step wrong");
  AST_RET_SP: assert property (
    take && i_op inside {[MBSC_OP_RETV:MBSC_OP_RETI]} |=> o_sp == SP_W'($past(o_sp) - MBSC_SP_STEP))
    else $error("return stack step wrong");
  AST_JUMP: assert property (
    take && i_op == MBSC_OP_JUMP |=> o_pc == $past(i_target)) else $error("jump target lost");
  AST_GIE: assert property (
    take && i_op inside {MBSC_OP_GIE_ON, MBSC_OP_GIE_OFF}
    |=> o_gie == ($past(i_op) == MBSC_OP_GIE_ON)) else $error("global enable wrong");
  AST_RETI_GIE: assert property (
    take && i_op == MBSC_OP_RETI |=> ##1 o_gie) else $error("interrupt return left enable low");
  AST_TWO_CYCLE: assert property (
    take && i_op inside {[MBSC_OP_CALL:MBSC_OP_PCADD], MBSC_OP_IDXM} |=> o_busy ##1 !o_busy)
    else $error("flow change not two cycles");
endmodule : mbsc_core_asserts
`default_nettype wire

// >>> tb/mbsc_mem_model.sv
// data ram and return stack standing behind the core
`timescale 1ns/100ps
`default_nettype none
module mbsc_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  input  wire logic [7:0]  i_sp,
  input  wire logic        i_stack_we,
  input  wire logic [10:0] i_stack_wdata,
  output logic      [10:0] o_stack_rdata
);
  logic [7:0]  ram [256];
  logic [10:0] stk [256];
  logic [7:0]  addr_q;
  // fixed fill, mirrored by the bench model
  initial for (int i = 0; i < 256; i++) ram[i] = 8'(i * 37 + 5);
  // the core writes one edge after its read, at the address it read;
  // a read of that byte meanwhile sees the new value
  assign o_rdata       = (i_we && i_addr == addr_q) ? i_wdata : ram[i_addr];
  // a return reads at the lowered pointer
  assign o_stack_rdata = stk[i_sp];
  // a call slot sits one step below the advanced pointer
  always @(posedge i_sys_clk) begin
    addr_q <= i_addr;
    if (i_we) ram[addr_q] <= i_wdata;
    if (i_stack_we) stk[8'(i_sp - 8'h02)] <= i_stack_wdata;
  end
endmodule : mbsc_mem_model
`default_nettype wire

// >>> tb/mbsc_core_test.sv
// self-checking bench for the skip, flow and system control core
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module mbsc_core_test;
  import mbsc_pkg::*;
  logic        i_sys_clk, rst_q, i_rst, i_instr_valid, i_use_mem, i_bit_io, i_wake;
  mbsc_op_t    i_op;
  logic [7:0]  i_imm, i_mem_rdata, i_io_rdata, i_mem_addr, o_acc, o_mem_wdata, o_sp;
  logic [2:0]  i_bit_sel;
  logic [10:0] i_target, i_stack_rdata, o_pc, o_stack_wdata;
  logic [3:0]  o_flags, e_fl;
  logic        o_gie, o_mem_we, o_stack_we, o_busy, o_suppress, o_bit_addr_err;
  logic        o_sys_halt, o_cpu_halt, o_chip_reset, o_wdt_clear;
  int          error_cnt, check_count, seed, cyc, e_pc, e_acc, e_sp, e_gie, i, k, r;
  int          mem [256];
  int          stk [$];
  mbsc_core dut_u (.i_sys_clk, .i_rst, .i_instr_valid, .i_op, .i_use_mem, .i_imm,
    .i_mem_rdata, .i_io_rdata, .i_mem_addr, .i_bit_sel, .i_bit_io, .i_target,
    .i_stack_rdata, .i_wake, .o_pc, .o_acc, .o_flags, .o_sp, .o_gie, .o_mem_we,
    .o_mem_wdata, .o_stack_we, .o_stack_wdata, .o_busy, .o_suppress,
    .o_bit_addr_err, .o_sys_halt, .o_cpu_halt, .o_chip_reset, .o_wdt_clear);
  mbsc_mem_model mem_u (.i_sys_clk, .i_addr(i_mem_addr), .i_we(o_mem_we),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata), .i_sp(o_sp), .i_stack_we(o_stack_we),
    .i_stack_wdata(o_stack_wdata), .o_stack_rdata(i_stack_rdata));
  // the bench plays the reset controller, so a software reset reaches i_rst
  assign i_rst = rst_q | o_chip_reset;
  initial begin
    i_sys_clk = 0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #4_000_000;
    error_cnt++;
    test_done();
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  function automatic logic [3:0] fl(int a, int b, bit s);
    int         q;
    logic [3:0] f;
    q = s ? a - b : a + b;
    f[MBSC_FLAG_Z] = (q & 255) == 0;
    f[MBSC_FLAG_C] = s ? a < b : q > 255;
    f[MBSC_FLAG_AC] = s ? (a & 15) < (b & 15) : (a & 15) + (b & 15) > 15;
    f[MBSC_FLAG_OV] = (((s ? a ^ b : ~(a ^ b)) & (a ^ q)) & 128) != 0;
    return f;
  endfunction : fl
  task automatic rst_model;
    e_pc = MBSC_PC_RST;
    e_acc = MBSC_ACC_RST;
    e_sp = MBSC_SP_RST;
    e_gie = 0;
    e_fl = '0;
    stk.delete();
  endtask : rst_model
  // ****************************************
  // one instruction, with the model run beside it
  // ****************************************
  task automatic ex(mbsc_op_t o, bit m, int v);
    int a, b, j, n, s;
    bit e;
    a = e_acc;
    e = 0;
    b = m ? mem[i_mem_addr] : v & 255;
    j = -1;
    s = 0;
    n = o inside {[MBSC_OP_CALL:MBSC_OP_PCADD], MBSC_OP_IDXM} ? 2 : 1;
    i_op = o;
    i_use_mem = m;
    i_imm = 8'(v);
    i_instr_valid = 1;
    case (o)
      MBSC_OP_CEQ, MBSC_OP_CNEQ: begin
        e_fl = fl(a, b, 1);
        s = (a == b) == (o == MBSC_OP_CEQ);
      end
      MBSC_OP_TBIT_LO, MBSC_OP_TBIT_HI: begin
        e = !i_bit_io && i_mem_addr > MBSC_BIT_RAM_HI;
        j = i_bit_io ? i_io_rdata : mem[i_mem_addr];
        s = !e && (j >> i_bit_sel & 1) == (o == MBSC_OP_TBIT_HI);
        j = -1;
      end
      MBSC_OP_INCSZ, MBSC_OP_DECSZ: begin
        if (m) a = b;
        e_fl = fl(a, 1, o == MBSC_OP_DECSZ);
        r = (o == MBSC_OP_DECSZ ? a - 1 : a + 1) & 255;
        s = r == 0;
        if (m) mem[i_mem_addr] = r;
        else e_acc = r;
      end
      MBSC_OP_CALL: begin
        stk.push_back((e_pc + 1) & 2047);
        e_sp += 2;
        j = i_target;
      end
      MBSC_OP_RETV, MBSC_OP_RET, MBSC_OP_RETI: begin
        if (o == MBSC_OP_RETV) e_acc = b;
        if (o == MBSC_OP_RETI) e_gie = 1;
        e_sp -= 2;
        j = stk.pop_back();
      end
      MBSC_OP_JUMP: j = i_target;
      MBSC_OP_PCADD: j = e_pc + a;
      MBSC_OP_GIE_ON, MBSC_OP_GIE_OFF: e_gie = o == MBSC_OP_GIE_ON;
      MBSC_OP_SWRESET: begin
        rst_model();
        j = MBSC_PC_RST;
      end
      default: ;
    endcase
    n += s;
    e_pc = (j >= 0 ? j : e_pc + 1 + s) & 2047;
    e_sp &= 255;
    @(negedge i_sys_clk);
    i_instr_valid = 0;
    for (cyc = 1; o_busy === 1'b1 && cyc < 9; cyc++) @(negedge i_sys_clk);
    `CHK("cycles", n, cyc)
    `CHK("wdt", 1'(o == MBSC_OP_WDCLR), o_wdt_clear)
    `CHK("chip reset", 1'(o == MBSC_OP_SWRESET), o_chip_reset)
    `CHK("bit range", e, o_bit_addr_err)
    // the reset that the strobe raises lands one edge later
    if (o == MBSC_OP_SWRESET) @(negedge i_sys_clk);
    `CHK("pc", 11'(e_pc), o_pc)
    `CHK("acc", 8'(e_acc), o_acc)
    `CHK("sp", 8'(e_sp), o_sp)
    `CHK("flags", e_fl, o_flags)
    `CHK("gie", 1'(e_gie), o_gie)
    `CHK("ram", 8'(mem[i_mem_addr]), i_mem_rdata)
    if (cyc == 9) test_done();
  endtask : ex
  task automatic halt(mbsc_op_t o);
    ex(o, 0, 0);
    `CHK("halt", 1'b1, o == MBSC_OP_SYSHALT ? o_sys_halt : o_cpu_halt)
    if (o == MBSC_OP_CPUHALT) `CHK("osc", 1'b0, o_sys_halt)
    i_wake = 1;
    @(negedge i_sys_clk);
    i_wake = 0;
    for (k = 0; (o_sys_halt | o_cpu_halt) !== 1'b0 && k < 9; k++) @(negedge i_sys_clk);
    `CHK("wake", 1'b0, o_sys_halt | o_cpu_halt)
    if (k == 9) test_done();
  endtask : halt
  initial begin
    seed = 32'h0731_8afa;
    rst_q = 1;
    i_op = MBSC_OP_NONE;
    {i_imm, i_io_rdata, i_mem_addr, i_bit_sel, i_target} = '0;
    {i_instr_valid, i_use_mem, i_bit_io, i_wake} = '0;
    for (k = 0; k < 256; k++) mem[k] = (k * 37 + 5) & 255;
    rst_model();
    repeat (20) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    rst_q = 0;
    // wrap both ways at the byte boundary
    ex(MBSC_OP_DECSZ, 0, 0);
    ex(MBSC_OP_INCSZ, 0, 0);
    $display("test wrap done");
    // random skips, bit tests, flow and enables; calls, returns, halts and software reset stay directed
    for (i = 0; i < 400; i++) begin
      i_mem_addr = 8'($random(seed)) & MBSC_BIT_RAM_HI;
      i_bit_sel = 3'($random(seed));
      i_bit_io = 1'($random(seed));
      i_io_rdata = 8'($random(seed));
      i_target = 11'($random(seed));
      r = 1 + $unsigned($random(seed)) % 20;
      if (!(r inside {7, [9:11], [15:17]}))
        ex(mbsc_op_t'(5'(r)), 1'($random(seed)), i % 3 ? $random(seed) : e_acc);
    end
    // bit tests past the bit-addressable ram never skip
    i_mem_addr = MBSC_BIT_RAM_HI + 8'h01;
    i_bit_io = 0;
    ex(MBSC_OP_TBIT_LO, 0, 0);
    ex(MBSC_OP_TBIT_HI, 0, 0);
    $display("test random done");
    // nested calls to the far end of program space, then every return
    i_target = 11'h7ff;
    ex(MBSC_OP_CALL, 0, 0);
    i_target = 11'h005;
    ex(MBSC_OP_CALL, 0, 0);
    ex(MBSC_OP_PCADD, 0, 0);
    ex(MBSC_OP_RETV, 0, 8'ha5);
    ex(MBSC_OP_GIE_OFF, 0, 0);
    ex(MBSC_OP_CALL, 0, 0);
    ex(MBSC_OP_RETI, 0, 0);
    ex(MBSC_OP_RET, 0, 0);
    $display("test calls done");
    halt(MBSC_OP_SYSHALT);
    halt(MBSC_OP_CPUHALT);
    ex(MBSC_OP_SWRESET, 0, 0);
    ex(MBSC_OP_DECSZ, 0, 0);
    $display("test system done");
    test_done();
  end
endmodule : mbsc_core_test
bind mbsc_core mbsc_core_asserts #(.PC_W(PC_W), .SP_W(SP_W)) chk_u (.i_sys_clk, .i_rst,
  .i_instr_valid, .i_op, .i_use_mem, .i_imm, .i_mem_rdata, .i_target, .o_pc, .o_acc,
  .o_flags, .o_sp, .o_gie, .o_busy, .o_suppress, .o_sys_halt, .o_cpu_halt);
`default_nettype wire
